// file: design/flash_read_path.v
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_defines.vh"

module flash_read_path #(
    parameter MEM_AW = 27
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_sclk,
    input wire i_cs_n,
    input wire [3:0] i_dq,
    output wire [3:0] o_dq,
    output wire [3:0] o_dq_oe,
    input wire [1:0] i_protocol,
    input wire i_dtr_en,
    input wire i_nv_addr4,
    input wire i_enter_addr4,
    input wire i_exit_addr4,
    input wire [3:0] i_dummy_cycles,
    output wire o_addr4_mode,
    output wire [31:0] o_rd_addr,
    output wire o_rd_discovery,
    output wire o_rd_strobe,
    input wire [7:0] i_rd_data,
    output wire o_busy,
    output wire o_bad_cmd
);

    localparam S_IDLE = 7'h01;
    localparam S_CMD = 7'h02;
    localparam S_DEC = 7'h04;
    localparam S_ADDR = 7'h08;
    localparam S_DUM = 7'h10;
    localparam S_DATA = 7'h20;
    localparam S_IGN = 7'h40;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [31:0] shift_in;
        input [31:0] v;
        input [3:0] b;
        input [2:0] w;
        begin
            case (w)
                3'd2: shift_in = {v[29:0], b[1:0]};
                3'd4: shift_in = {v[27:0], b[3:0]};
                default: shift_in = {v[30:0], b[0]};
            endcase
        end
    endfunction

    function [3:0] out_bits;
        input [7:0] v;
        input [2:0] w;
        begin
            case (w)
                3'd2: out_bits = {2'b00, v[7:6]};
                3'd4: out_bits = v[7:4];
                default: out_bits = {2'b00, v[7], 1'b0};
            endcase
        end
    endfunction

    function [3:0] oe_bits;
        input [2:0] w;
        begin
            case (w)
                3'd2: oe_bits = 4'h3;
                3'd4: oe_bits = 4'hF;
                default: oe_bits = 4'h2;
            endcase
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------
    wire [5:0] pins_s;
    wire sclk_s;
    wire cs_n_s;
    wire [3:0] dq_s;
    reg sclk_p_q;

    pin_sync #(
        .WIDTH(6)
    ) u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async({i_sclk, i_cs_n, i_dq}),
        .o_sync(pins_s)
    );

    assign sclk_s = pins_s[5];
    assign cs_n_s = pins_s[4];
    assign dq_s = pins_s[3:0];

    always @(posedge i_clk) begin
        if (i_srst) begin
            sclk_p_q <= 1'b0;
        end else begin
            sclk_p_q <= sclk_s;
        end
    end

    wire rise = sclk_s & ~sclk_p_q;
    wire fall = ~sclk_s & sclk_p_q;

    // ----------------------------------------
    // address mode register
    // ----------------------------------------
    reg addr4_q;

    always @(posedge i_clk) begin
        if (i_srst) begin
            addr4_q <= i_nv_addr4;
        end else if (i_enter_addr4) begin
            addr4_q <= 1'b1;
        end else if (i_exit_addr4) begin
            addr4_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // opcode decode
    // ----------------------------------------
    reg [7:0] op_q;
    wire dec_valid;
    wire dec_disc;
    wire dec_a4;
    wire dec_dtr;
    wire [2:0] dec_aw;
    wire [2:0] dec_dw;
    wire [3:0] dec_dum;

    read_decoder u_dec (
        .i_opcode(op_q),
        .i_protocol(i_protocol),
        .i_dtr_en(i_dtr_en),
        .i_addr4_mode(addr4_q),
        .i_dummy_cycles(i_dummy_cycles),
        .o_valid(dec_valid),
        .o_discovery(dec_disc),
        .o_addr4(dec_a4),
        .o_dtr(dec_dtr),
        .o_addr_lines(dec_aw),
        .o_data_lines(dec_dw),
        .o_dummy(dec_dum)
    );

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    reg [6:0] state_q;
    reg [5:0] cnt_q;
    reg [31:0] addr_q;
    reg disc_q;
    reg dtr_q;
    reg a4_q;
    reg [2:0] aw_q;
    reg [2:0] dw_q;
    reg [3:0] dcnt_q;
    reg started_q;
    reg [7:0] sh_q;
    reg [3:0] rem_q;
    reg [3:0] dq_q;
    reg [3:0] oe_q;
    reg strobe_q;
    reg bad_q;

    wire [2:0] pw = (i_protocol == `PROTO_DUAL) ? 3'd2 :
                    (i_protocol == `PROTO_QUAD) ? 3'd4 : 3'd1;
    wire cmd_edge = rise | (i_dtr_en & fall);
    wire addr_edge = rise | (dtr_q & fall & (cnt_q != 6'd0));
    wire out_edge = fall | (dtr_q & started_q & rise);
    wire [31:0] op_next = shift_in({24'h000000, op_q}, dq_s, pw);
    wire [31:0] addr_next = shift_in(addr_q, dq_s, aw_q);
    wire [5:0] abits = a4_q ? `ADDR4_BITS : `ADDR3_BITS;
    wire [31:0] mem_mask = ~(32'hFFFFFFFF << MEM_AW);
    wire [31:0] wrap_mask = disc_q ? `DISCOVERY_MASK : mem_mask;
    wire [7:0] cur_byte = (rem_q == 4'h0) ? i_rd_data : sh_q;
    wire [3:0] rem_base = (rem_q == 4'h0) ? `BYTE_BITS : rem_q;

    always @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= S_IDLE;
            cnt_q <= 6'd0;
            op_q <= 8'h00;
            addr_q <= 32'h00000000;
            disc_q <= 1'b0;
            dtr_q <= 1'b0;
            a4_q <= 1'b0;
            aw_q <= 3'd1;
            dw_q <= 3'd1;
            dcnt_q <= 4'h0;
            started_q <= 1'b0;
            sh_q <= 8'h00;
            rem_q <= 4'h0;
            dq_q <= 4'h0;
            oe_q <= 4'h0;
            strobe_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            strobe_q <= 1'b0;
            bad_q <= 1'b0;
            if (cs_n_s) begin
                state_q <= S_IDLE;
                oe_q <= 4'h0;
                started_q <= 1'b0;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        state_q <= S_CMD;
                        cnt_q <= 6'd0;
                        op_q <= 8'h00;
                    end
                    S_CMD: begin
                        if (cmd_edge) begin
                            op_q <= op_next[7:0];
                            cnt_q <= cnt_q + {3'd0, pw};
                            if (cnt_q + {3'd0, pw} >= `OPCODE_BITS) begin
                                state_q <= S_DEC;
                            end
                        end
                    end
                    S_DEC: begin
                        disc_q <= dec_disc;
                        dtr_q <= dec_dtr;
                        a4_q <= dec_a4;
                        aw_q <= dec_aw;
                        dw_q <= dec_dw;
                        dcnt_q <= dec_dum;
                        cnt_q <= 6'd0;
                        addr_q <= 32'h00000000;
                        rem_q <= 4'h0;
                        if (dec_valid) begin
                            state_q <= S_ADDR;
                        end else begin
                            state_q <= S_IGN;
                            bad_q <= 1'b1;
                        end
                    end
                    S_ADDR: begin
                        if (addr_edge) begin
                            addr_q <= addr_next;
                            cnt_q <= cnt_q + {3'd0, aw_q};
                            if (cnt_q + {3'd0, aw_q} >= abits) begin
                                addr_q <= addr_next & wrap_mask;
                                if (dcnt_q == 4'h0) begin
                                    state_q <= S_DATA;
                                end else begin
                                    state_q <= S_DUM;
                                end
                            end
                        end
                    end
                    S_DUM: begin
                        if (rise) begin
                            dcnt_q <= dcnt_q - 4'h1;
                            if (dcnt_q == 4'h1) begin
                                state_q <= S_DATA;
                            end
                        end
                    end
                    S_DATA: begin
                        if (out_edge) begin
                            started_q <= 1'b1;
                            oe_q <= oe_bits(dw_q);
                            dq_q <= out_bits(cur_byte, dw_q);
                            sh_q <= cur_byte << dw_q;
                            rem_q <= rem_base - {1'b0, dw_q};
                            if (rem_q == 4'h0) begin
                                strobe_q <= 1'b1;
                                addr_q <= (addr_q + 32'h1) & wrap_mask;
                            end
                        end
                    end
                    S_IGN: begin
                        oe_q <= 4'h0;
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_dq = dq_q;
    assign o_dq_oe = oe_q;
    assign o_addr4_mode = addr4_q;
    assign o_rd_addr = addr_q;
    assign o_rd_discovery = disc_q;
    assign o_rd_strobe = strobe_q;
    assign o_busy = (state_q != S_IDLE);
    assign o_bad_cmd = bad_q;

endmodule // flash_read_path

`default_nettype wire

// file: design/flash_read_defines.vh
`ifndef FLASH_READ_DEFINES_VH
`define FLASH_READ_DEFINES_VH

// ----------------------------------------
// protocol codes on i_protocol
// ----------------------------------------
`define PROTO_EXT 2'h0
`define PROTO_DUAL 2'h1
`define PROTO_QUAD 2'h2

// ----------------------------------------
// opcodes, 3-byte and configurable address
// ----------------------------------------
`define OP_DISCOVERY 8'h5A
`define OP_READ 8'h03
`define OP_FAST 8'h0B
`define OP_DUAL_OUT 8'h3B
`define OP_DUAL_IO 8'hBB
`define OP_QUAD_OUT 8'h6B
`define OP_QUAD_IO 8'hEB
`define OP_DTR_FAST 8'h0D
`define OP_DTR_DUAL_OUT 8'h3D
`define OP_DTR_DUAL_IO 8'hBD
`define OP_DTR_QUAD_OUT 8'h6D
`define OP_DTR_QUAD_IO 8'hED
`define OP_WORD_READ 8'hE7

// ----------------------------------------
// opcodes, dedicated 4-byte address
// ----------------------------------------
`define OP4_READ 8'h13
`define OP4_FAST 8'h0C
`define OP4_DUAL_OUT 8'h3C
`define OP4_DUAL_IO 8'hBC
`define OP4_QUAD_OUT 8'h6C
`define OP4_QUAD_IO 8'hEC
`define OP4_DTR_FAST 8'h0E
`define OP4_DTR_DUAL_IO 8'hBE
`define OP4_DTR_QUAD_IO 8'hEE

// ----------------------------------------
// phase lengths and table geometry
// ----------------------------------------
`define OPCODE_BITS 6'd8
`define ADDR3_BITS 6'd24
`define ADDR4_BITS 6'd32
`define DISCOVERY_DUMMY 4'h8
`define WORD_READ_DUMMY 4'h4
`define DISCOVERY_MASK 32'h000007FF
`define BYTE_BITS 4'h8

`endif

// file: design/pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 6
) (
    input wire i_clk,
    input wire i_srst,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    // ----------------------------------------
    // two flops per bit
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge i_clk) begin
                if (i_srst) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate

endmodule // pin_sync

`default_nettype wire

// file: design/read_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_defines.vh"

module read_decoder (
    input wire [7:0] i_opcode,
    input wire [1:0] i_protocol,
    input wire i_dtr_en,
    input wire i_addr4_mode,
    input wire [3:0] i_dummy_cycles,
    output reg o_valid,
    output reg o_discovery,
    output reg o_addr4,
    output reg o_dtr,
    output reg [2:0] o_addr_lines,
    output reg [2:0] o_data_lines,
    output reg [3:0] o_dummy
);

    reg [2:0] a_ext;
    reg [2:0] d_ext;
    reg [2:0] pw;
    reg known;
    reg dtr_cmd;
    reg a4_cmd;

    // ----------------------------------------
    // opcode table
    // ----------------------------------------
    always @* begin
        known = 1'b1;
        dtr_cmd = 1'b0;
        a4_cmd = 1'b0;
        a_ext = 3'd1;
        d_ext = 3'd1;
        o_discovery = 1'b0;
        o_dummy = i_dummy_cycles;
        case (i_opcode)
            `OP_DISCOVERY: begin
                o_discovery = 1'b1;
                o_dummy = `DISCOVERY_DUMMY;
            end
            `OP_READ, `OP4_READ: begin
                o_dummy = 4'h0;
            end
            `OP_FAST, `OP4_FAST: begin
            end
            `OP_DUAL_OUT, `OP4_DUAL_OUT: begin
                d_ext = 3'd2;
            end
            `OP_DUAL_IO, `OP4_DUAL_IO: begin
                a_ext = 3'd2;
                d_ext = 3'd2;
            end
            `OP_QUAD_OUT, `OP4_QUAD_OUT: begin
                d_ext = 3'd4;
            end
            `OP_QUAD_IO, `OP4_QUAD_IO: begin
                a_ext = 3'd4;
                d_ext = 3'd4;
            end
            `OP_WORD_READ: begin
                a_ext = 3'd4;
                d_ext = 3'd4;
                o_dummy = `WORD_READ_DUMMY;
            end
            `OP_DTR_FAST, `OP4_DTR_FAST: begin
                dtr_cmd = 1'b1;
            end
            `OP_DTR_DUAL_OUT: begin
                dtr_cmd = 1'b1;
                d_ext = 3'd2;
            end
            `OP_DTR_DUAL_IO, `OP4_DTR_DUAL_IO: begin
                dtr_cmd = 1'b1;
                a_ext = 3'd2;
                d_ext = 3'd2;
            end
            `OP_DTR_QUAD_OUT: begin
                dtr_cmd = 1'b1;
                d_ext = 3'd4;
            end
            `OP_DTR_QUAD_IO, `OP4_DTR_QUAD_IO: begin
                dtr_cmd = 1'b1;
                a_ext = 3'd4;
                d_ext = 3'd4;
            end
            default: begin
                known = 1'b0;
            end
        endcase
        case (i_opcode)
            `OP4_READ, `OP4_FAST, `OP4_DUAL_OUT, `OP4_DUAL_IO, `OP4_QUAD_OUT,
            `OP4_QUAD_IO, `OP4_DTR_FAST, `OP4_DTR_DUAL_IO, `OP4_DTR_QUAD_IO: begin
                a4_cmd = 1'b1;
            end
            default: begin
                a4_cmd = 1'b0;
            end
        endcase
        case (i_protocol)
            `PROTO_DUAL: pw = 3'd2;
            `PROTO_QUAD: pw = 3'd4;
            default: pw = 3'd1;
        endcase
        // ----------------------------------------
        // line widths and mode resolution
        // ----------------------------------------
        o_addr_lines = (i_protocol == `PROTO_EXT) ? a_ext : pw;
        o_data_lines = (i_protocol == `PROTO_EXT) ? d_ext : pw;
        o_dtr = (dtr_cmd | i_dtr_en) & ~o_discovery;
        o_addr4 = a4_cmd | (i_addr4_mode & ~o_discovery);
        o_valid = known & (i_protocol != 2'h3);
        if (i_protocol != `PROTO_EXT && d_ext != 3'd1 && d_ext != pw) begin
            o_valid = 1'b0;
        end
        if (i_opcode == `OP_WORD_READ && (i_protocol == `PROTO_DUAL || o_dtr)) begin
            o_valid = 1'b0;
        end
    end

endmodule // read_decoder

`default_nettype wire

// file: sim/flash_read_path_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module flash_read_path_checker #(
    parameter MEM_AW = 27
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic [3:0] i_dq,
    input wire logic [3:0] o_dq,
    input wire logic [3:0] o_dq_oe,
    input wire logic [1:0] i_protocol,
    input wire logic i_dtr_en,
    input wire logic i_nv_addr4,
    input wire logic i_enter_addr4,
    input wire logic i_exit_addr4,
    input wire logic [3:0] i_dummy_cycles,
    input wire logic o_addr4_mode,
    input wire logic [31:0] o_rd_addr,
    input wire logic o_rd_discovery,
    input wire logic o_rd_strobe,
    input wire logic [7:0] i_rd_data,
    input wire logic o_busy,
    input wire logic o_bad_cmd
);
    localparam logic [32:0] SPAN = 33'h1 << MEM_AW;
    localparam logic [31:0] MASK = SPAN[31:0] - 32'h1;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // ----
    // checks
    // ----
    rst_quiet_a: assert property ($fell(i_srst) |-> o_dq_oe == 4'h0 && !o_busy)
        else $error("drive after reset");
    quad_lines_a: assert property (i_protocol == 2'h2 |-> o_dq_oe inside {4'h0, 4'hF})
        else $error("quad lane enables");
    dual_lines_a: assert property (i_protocol == 2'h1 |-> o_dq_oe inside {4'h0, 4'h3})
        else $error("dual lane enables");
    strobe_drive_a: assert property (o_rd_strobe |-> o_dq_oe != 4'h0)
        else $error("fetch without drive");
    mem_step_a: assert property (o_rd_strobe && !o_rd_discovery |->
        o_rd_addr == (($past(o_rd_addr) + 32'h1) & MASK))
        else $error("memory address step");
    table_wrap_a: assert property (o_rd_strobe && o_rd_discovery |->
        o_rd_addr == (($past(o_rd_addr) + 32'h1) & 32'h7FF))
        else $error("table address step");
    deselect_end_a: assert property ($rose(i_cs_n) |-> ##[1:5] (o_dq_oe == 4'h0 && !o_busy))
        else $error("no release on deselect");
    refuse_quiet_a: assert property (o_bad_cmd |-> (o_dq_oe == 4'h0) [*4])
        else $error("drive after refusal");
    enter_mode_a: assert property (i_enter_addr4 |=> o_addr4_mode)
        else $error("enter mode");
    exit_mode_a: assert property (i_exit_addr4 && !i_enter_addr4 |=> !o_addr4_mode)
        else $error("exit mode");
    cover property (o_rd_strobe && o_rd_discovery);
    cover property (o_rd_strobe && o_dq_oe == 4'hF);
    cover property (o_bad_cmd);
endmodule // flash_read_path_checker
`default_nettype wire

// file: sim/flash_host.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host (
    input wire logic [3:0] i_pin,
    input wire logic [1:0] i_ddr,
    output var logic o_cs_n,
    output var logic o_sclk,
    output var logic [3:0] o_dq
);
    logic [7:0] rx [0:3];
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_dq = 4'h5;
    end
    // clock idles low, data changes on fall
    task automatic pulse;
        o_sclk = 1'b1;
        #160;
        o_sclk = 1'b0;
    endtask
    task automatic send(input logic [31:0] v, input int n, input int w, input logic d);
        logic [31:0] x;
        for (int i = n / w - 1; i >= 0; i--) begin
            x = v >> (i * w);
            o_dq = (w == 1) ? {~o_dq[3:1], x[0]} :
                (w == 2) ? {~o_dq[3:2], x[1:0]} : x[3:0];
            if (d) begin
                #80;
                o_sclk = ~o_sclk;
                #80;
            end else begin
                #160;
                pulse();
            end
        end
    endtask
    task automatic frame(input logic [7:0] op, input int ow, input logic [31:0] a,
        input int ab, input int aw, input int dm, input int nb, input int dw);
        logic [7:0] b;
        o_cs_n = 1'b0;
        #160;
        send({24'h0, op}, 8, ow, i_ddr[1]);
        if (i_ddr[0]) #80;
        send(a, ab, aw, i_ddr[0]);
        repeat (dm) begin
            o_dq = ~o_dq;
            #160;
            pulse();
        end
        for (int k = 0; k < nb; k++) begin
            for (int t = 0; t < 8 / dw; t++) begin
                o_dq = ~o_dq;
                #160;
                b = (b << dw) | (dw == 1 ? {7'h0, i_pin[1]} :
                    dw == 2 ? {6'h0, i_pin[1:0]} : {4'h0, i_pin});
                if (i_ddr[0]) o_sclk = ~o_sclk;
                else pulse();
            end
            rx[k] = b;
        end
        #160;
        o_cs_n = 1'b1;
        #320;
    endtask
endmodule // flash_host
`default_nettype wire

// file: sim/flash_read_path_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_read_path_tb;
    localparam int MEM_AW = 16;
    logic clk = 1'b0;
    logic srst, cs_n, sclk, nv_addr4, enter, exit_p, addr4_mode, rd_disc, rd_strobe;
    logic busy, bad_cmd, bad_seen, dtr_en;
    logic [3:0] host_dq, pin, dut_dq, dut_oe, dummy;
    logic [1:0] protocol, ddr;
    logic [31:0] rd_addr;
    logic [7:0] rd_data;
    int errors = 0;
    int n_compared = 0;
    logic [7:0] ops [22] = '{8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'h0D, 8'h3D,
        8'hBD, 8'h6D, 8'hED, 8'hE7, 8'h13, 8'h0C, 8'h3C, 8'hBC, 8'h6C, 8'hEC,
        8'h0E, 8'hBE, 8'hEE, 8'h5A};
    function automatic logic [7:0] mem_byte(input logic d, input logic [31:0] a);
        return d ? (a[7:0] ^ 8'hA5) : (a[7:0] + a[15:8] + 8'h11);
    endfunction
    always #20 clk = ~clk;
    assign pin = (dut_oe & dut_dq) | (~dut_oe & host_dq);
    assign rd_data = mem_byte(rd_disc, rd_addr);
    always @(posedge clk) if (bad_cmd === 1'b1) bad_seen <= 1'b1;
    flash_host i_host (.i_pin(pin), .i_ddr(ddr), .o_cs_n(cs_n), .o_sclk(sclk), .o_dq(host_dq));
    flash_read_path #(.MEM_AW(MEM_AW)) i_dut (.i_clk(clk), .i_srst(srst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_dq(pin), .o_dq(dut_dq), .o_dq_oe(dut_oe), .i_protocol(protocol),
        .i_dtr_en(dtr_en), .i_nv_addr4(nv_addr4), .i_enter_addr4(enter),
        .i_exit_addr4(exit_p), .i_dummy_cycles(dummy), .o_addr4_mode(addr4_mode),
        .o_rd_addr(rd_addr), .o_rd_discovery(rd_disc), .o_rd_strobe(rd_strobe),
        .i_rd_data(rd_data), .o_busy(busy), .o_bad_cmd(bad_cmd));
    // ----
    // tasks
    // ----
    task automatic finish_test;
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic settle;
        for (int n = 0; n < 20 && busy !== 1'b0; n++) @(posedge clk);
        if (busy !== 1'b0) begin
            errors++;
            finish_test();
        end
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] op, input int ow, input logic [31:0] a, input int ab,
        input int aw, input int dm, input int nb, input int dw, input logic d);
        logic [31:0] m;
        m = d ? 32'h7FF : (32'h1 << MEM_AW) - 32'h1;
        i_host.frame(op, ow, a, ab, aw, dm, nb, dw);
        for (int k = 0; k < nb; k++)
            check("read byte", {24'h0, mem_byte(d, (a + k) & m)}, {24'h0, i_host.rx[k]});
        check("line enable", 32'h0, {28'h0, dut_oe});
        settle();
    endtask
    task automatic dec(input logic [1:0] p, input logic [7:0] op, input logic bad);
        protocol = p;
        bad_seen = 1'b0;
        i_host.frame(op, p == 2'h0 ? 1 : p == 2'h1 ? 2 : 4, 32'h0, 0, 1, 0, 0, 1);
        check("refusal", {31'h0, bad}, {31'h0, bad_seen});
        settle();
    endtask
    task automatic mode(input logic en, input logic ex, input logic exp);
        enter = en;
        exit_p = ex;
        @(posedge clk);
        #1;
        enter = 1'b0;
        exit_p = 1'b0;
        @(posedge clk);
        #1;
        check("address mode", {31'h0, exp}, {31'h0, addr4_mode});
    endtask
    task automatic reset_run(input logic nv);
        srst = 1'b1;
        nv_addr4 = nv;
        repeat (8) @(posedge clk);
        #1;
        srst = 1'b0;
        @(posedge clk);
        #1;
        check("mode after reset", {31'h0, nv}, {31'h0, addr4_mode});
    endtask
    // ----
    // sequence
    // ----
    initial begin
        #2000000;
        errors++;
        finish_test();
    end
    initial begin
        protocol = 2'h0;
        dtr_en = 1'b0;
        ddr = 2'h0;
        enter = 1'b0;
        exit_p = 1'b0;
        dummy = 4'h0;
        bad_seen = 1'b0;
        reset_run(1'b0);
        check("busy after reset", 32'h0, {31'h0, busy});
        rd(8'h03, 1, 32'hFFFF, 24, 1, 0, 3, 1, 1'b0);
        dummy = 4'h3;
        rd(8'h0B, 1, 32'h1234, 24, 1, 3, 2, 1, 1'b0);
        dummy = 4'h5;
        rd(8'h3B, 1, 32'h1234, 24, 1, 5, 1, 2, 1'b0);
        rd(8'hBB, 1, 32'h2222, 24, 2, 5, 1, 2, 1'b0);
        rd(8'h6B, 1, 32'h3333, 24, 1, 5, 2, 4, 1'b0);
        rd(8'hE7, 1, 32'h0200, 24, 4, 4, 2, 4, 1'b0);
        rd(8'h13, 1, 32'hABCD, 32, 1, 0, 1, 1, 1'b0);
        rd(8'hBC, 1, 32'h4444, 32, 2, 5, 1, 2, 1'b0);
        ddr = 2'h1;
        rd(8'h0D, 1, 32'h5678, 24, 1, 5, 2, 1, 1'b0);
        dtr_en = 1'b1;
        ddr = 2'h3;
        rd(8'h0B, 1, 32'h9ABC, 24, 1, 5, 2, 1, 1'b0);
        dec(2'h0, 8'hE7, 1'b1);
        dtr_en = 1'b0;
        ddr = 2'h0;
        protocol = 2'h1;
        rd(8'hBB, 2, 32'h5555, 24, 2, 5, 2, 2, 1'b0);
        protocol = 2'h2;
        rd(8'hEB, 4, 32'hFFFE, 24, 4, 5, 3, 4, 1'b0);
        protocol = 2'h0;
        mode(1'b1, 1'b0, 1'b1);
        rd(8'h5A, 1, 32'h07FF, 24, 1, 8, 2, 1, 1'b1);
        rd(8'h03, 1, 32'h0010, 32, 1, 0, 1, 1, 1'b0);
        mode(1'b1, 1'b1, 1'b1);
        mode(1'b0, 1'b1, 1'b0);
        reset_run(1'b1);
        mode(1'b0, 1'b1, 1'b0);
        foreach (ops[i]) dec(2'h0, ops[i], 1'b0);
        dec(2'h0, 8'h00, 1'b1);
        dec(2'h1, 8'hE7, 1'b1);
        dec(2'h2, 8'hE7, 1'b0);
        finish_test();
    end
endmodule // flash_read_path_tb
bind flash_read_path flash_read_path_checker #(.MEM_AW(MEM_AW)) i_chk (.i_clk(i_clk),
    .i_srst(i_srst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_dq(i_dq), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .i_protocol(i_protocol), .i_dtr_en(i_dtr_en),
    .i_nv_addr4(i_nv_addr4), .i_enter_addr4(i_enter_addr4), .i_exit_addr4(i_exit_addr4),
    .i_dummy_cycles(i_dummy_cycles), .o_addr4_mode(o_addr4_mode), .o_rd_addr(o_rd_addr),
    .o_rd_discovery(o_rd_discovery), .o_rd_strobe(o_rd_strobe), .i_rd_data(i_rd_data),
    .o_busy(o_busy), .o_bad_cmd(o_bad_cmd));
`default_nettype wire
